/* File: design/hpr_port_regs.sv */
/*
 * hpr_port_regs: AHB-Lite register bank holding per-port HS drive boost,
 * DP/DM pin swap and physical-to-logical port renumbering for downstream
 * ports 1 and 2 (swap also for port 3).
 * Assumes a single AHB-Lite master, word transfers only, and transmit
 * data inputs coming from logic on core_clk.
 */
// Added by the designer: the AHB-Lite interface to the registers.
//
// Notes on behaviour
// - Boost bits 6:4 select the HS current boost of downstream port 2.
// - Boost bits 2:0 select the HS current boost of downstream port 1.
// - Boost codes map 0..5 to nominal,-5,+10,+5,+20,+15 percent, and 6 to +25.
// - A swap bit of 0 puts D+ on DP and D- on DM, and 1 exchanges them.
// - Swap bits 3,2,1 serve ports 3,2,1, and bits 7:4 and 0 are reserved.
// - The ports 1 and 2 remap register resets to identity, value 21 hex.
// - Remapping applies only while the renumbering enable is set.
// - Remap bits 7:4 assign physical port 2: 0 off, 1 to 3 logical ports.
// - The hub reports only its count of enabled ports, and the host numbers.
// - Remap bits 3:0 assign physical port 1: 0 off, 1 to 3 logical ports.
// - Remap codes 4 to 15 act exactly like the disabled code 0.
`timescale 1ns/1ps

module hpr_port_regs (
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	input  wire logic             hsel,
	input  wire logic [31:0]      haddr,
	input  wire logic [1:0]       htrans,
	input  wire logic             hwrite,
	input  wire logic [2:0]       hsize,
	input  wire logic [31:0]      hwdata,
	input  wire logic             hready,
	output logic                  hreadyout,
	output logic [1:0]            hresp,
	output logic [31:0]           hrdata,
	input  wire logic [3:1]       txPlus,
	input  wire logic [3:1]       txMinus,
	output logic [3:1]            dpOut,
	output logic [3:1]            dmOut,
	output logic [2:0]            hs_current_boost_port_one,
	output logic [2:0]            hs_current_boost_port_two,
	output logic signed [7:0]     boostPctOne,
	output logic signed [7:0]     boostPctTwo,
	output logic [3:0]            logicalPortOne,
	output logic [3:0]            logicalPortTwo,
	output logic [1:0]            reportedPortCount
);
	import hpr_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  boost;
		logic [7:0]  swap;
		logic [7:0]  remap;
		logic [7:0]  ctrl;
		logic        wrPend;
		logic [7:0]  wrIdx;
		logic        wrTop;
		logic [31:0] rdata;
		logic [3:1]  dp;
		logic [3:1]  dm;
		logic [3:0]  mapOne;
		logic [3:0]  mapTwo;
		logic [1:0]  count;
		logic signed [7:0] pctOne;
		logic signed [7:0] pctTwo;
	} hpr_state_t;

	hpr_state_t state_q;
	hpr_state_t state_d;

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	// boost code to percent
	function automatic logic signed [7:0] boostPct(input logic [2:0] code);
		logic signed [7:0] pct;
		pct = PCT_NOM;
		case (code)
			BST_NOM: pct = PCT_NOM;
			BST_M5:  pct = PCT_M5;
			BST_P10: pct = PCT_P10;
			BST_P5:  pct = PCT_P5;
			BST_P20: pct = PCT_P20;
			BST_P15: pct = PCT_P15;
			BST_P25: pct = PCT_P25;
			default: pct = PCT_NOM;
		endcase
		return pct;
	endfunction : boostPct

	function automatic logic [3:0] mapCode(input logic [3:0] code);
		logic [3:0] res;
		res = MAP_OFF;
		if (code <= MAP_MAXOK) begin
			res = code;
		end
		return res;
	endfunction : mapCode

	function automatic logic [7:0] readReg(input hpr_state_t s, input logic [7:0] idx);
		logic [7:0] v;
		v = 8'h00;
		if (idx == IDX_BOOST) begin
			v = s.boost;
		end else if (idx == IDX_SWAP) begin
			v = s.swap;
		end else if (idx == IDX_REMAP) begin
			v = s.remap;
		end else if (idx == IDX_CTRL) begin
			v = s.ctrl;
		end
		return v;
	endfunction : readReg

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	logic        addrPhase;
	logic [7:0]  aIdx;
	logic        aTop;
	logic [31:0] statusWord;
	logic        enable;
	logic [3:0]  one;
	logic [3:0]  two;

	always_comb begin
		state_d = state_q;
		addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ);
		aIdx = haddr[ADDR_IDX_HI:ADDR_IDX_LO];
		aTop = (haddr[31:ADDR_TOP_LO] == '0);
		statusWord = WORD_ZERO;
		enable = 1'b0;
		one = MAP_OFF;
		two = MAP_OFF;

		// data phase of a write; reserved bits masked off
		if (state_q.wrPend && state_q.wrTop) begin
			if (state_q.wrIdx == IDX_BOOST) begin
				state_d.boost = hwdata[7:0] & MASK_BOOST;
			end else if (state_q.wrIdx == IDX_SWAP) begin
				// swap bits 3 to 1 only
				state_d.swap = hwdata[7:0] & MASK_SWAP;
			end else if (state_q.wrIdx == IDX_REMAP) begin
				state_d.remap = hwdata[7:0] & MASK_REMAP;
			end else if (state_q.wrIdx == IDX_CTRL) begin
				state_d.ctrl = hwdata[7:0] & MASK_CTRL;
			end
		end

		// address phase
		state_d.wrPend = addrPhase && hwrite;
		state_d.wrIdx = aIdx;
		state_d.wrTop = aTop;

		// port outputs follow the updated registers
		// port two and port one boost fields
		state_d.pctTwo = boostPct(state_d.boost[BOOST_TWO_LO +: BOOST_W]);
		state_d.pctOne = boostPct(state_d.boost[BOOST_ONE_LO +: BOOST_W]);

		for (int p = SWAP_ONE_BIT; p <= SWAP_THR_BIT; p++) begin
			if (state_d.swap[p]) begin
				state_d.dp[p] = txMinus[p];
				state_d.dm[p] = txPlus[p];
			end else begin
				state_d.dp[p] = txPlus[p];
				state_d.dm[p] = txMinus[p];
			end
		end

		enable = state_d.ctrl[CTRL_EN_BIT];
		if (enable) begin
			one = mapCode(state_d.remap[MAP_ONE_LO +: MAP_W]);
			two = mapCode(state_d.remap[MAP_TWO_LO +: MAP_W]);
		end else begin
			one = DEF_ONE;
			two = DEF_TWO;
		end
		state_d.mapOne = one;
		state_d.mapTwo = two;

		// report only the enabled port count
		state_d.count = {1'b0, (one != MAP_OFF)} + {1'b0, (two != MAP_OFF)};

		statusWord[MAP_ONE_LO +: MAP_W] = one;
		statusWord[STAT_TWO_LO +: MAP_W] = two;
		statusWord[STAT_CNT_LO +: 2] = state_d.count;

		// read data from the updated copy, so a read right after a write sees it
		if (addrPhase && !hwrite) begin
			if (!aTop) begin
				state_d.rdata = WORD_ZERO;
			end else if (aIdx == IDX_STATUS) begin
				state_d.rdata = statusWord;
			end else begin
				state_d.rdata = {24'h00_0000, readReg(state_d, aIdx)};
			end
		end

		// ------------------------------------------------------------
		// reset
		// ------------------------------------------------------------
		if (!rst_n) begin
			state_d = '0;
			state_d.boost = RST_BOOST;
			state_d.swap = RST_SWAP;
			state_d.remap = RST_REMAP;
			state_d.ctrl = RST_CTRL;
			state_d.mapOne = DEF_ONE;
			state_d.mapTwo = DEF_TWO;
			state_d.count = 2'h2;
		end
	end

	always_ff @(posedge core_clk) begin
		state_q <= state_d;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign hreadyout = 1'b1;
	assign hresp = HRESP_OKAY;
	assign hrdata = state_q.rdata;
	assign dpOut = state_q.dp;
	assign dmOut = state_q.dm;
	assign hs_current_boost_port_one = state_q.boost[BOOST_ONE_LO +: BOOST_W];
	assign hs_current_boost_port_two = state_q.boost[BOOST_TWO_LO +: BOOST_W];
	assign boostPctOne = state_q.pctOne;
	assign boostPctTwo = state_q.pctTwo;
	assign logicalPortOne = state_q.mapOne;
	assign logicalPortTwo = state_q.mapTwo;
	assign reportedPortCount = state_q.count;

endmodule : hpr_port_regs

/* File: design/hpr_pkg.sv */
/*
 * hpr_pkg: constants shared by the hub port boost, swap and
 * remap register block.
 * Assumes a 32-bit AHB-Lite bus; each register takes one aligned word
 * at byte address four times its index.
 */
package hpr_pkg;

	// ------------------------------------------------------------
	// register indices (byte address = index * 4)
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_STATUS = 8'hf7;
	localparam logic [7:0] IDX_BOOST  = 8'hf8;
	localparam logic [7:0] IDX_CTRL   = 8'hf9;
	localparam logic [7:0] IDX_SWAP   = 8'hfa;
	localparam logic [7:0] IDX_REMAP  = 8'hfb;

	// ------------------------------------------------------------
	// address decode layout
	// ------------------------------------------------------------
	localparam int ADDR_IDX_LO = 2;
	localparam int ADDR_IDX_HI = 9;
	localparam int ADDR_TOP_LO = 10;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_BOOST = 8'h00;
	localparam logic [7:0] RST_SWAP  = 8'h00;
	localparam logic [7:0] RST_REMAP = 8'h21;
	localparam logic [7:0] RST_CTRL  = 8'h00;

	// ------------------------------------------------------------
	// writable bit masks; other bits read zero
	// ------------------------------------------------------------
	localparam logic [7:0] MASK_BOOST = 8'h77;
	localparam logic [7:0] MASK_SWAP  = 8'h0e;
	localparam logic [7:0] MASK_REMAP = 8'hff;
	localparam logic [7:0] MASK_CTRL  = 8'h01;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int BOOST_ONE_LO = 0;
	localparam int BOOST_TWO_LO = 4;
	localparam int BOOST_W      = 3;
	localparam int SWAP_ONE_BIT = 1;
	localparam int SWAP_TWO_BIT = 2;
	localparam int SWAP_THR_BIT = 3;
	localparam int MAP_ONE_LO   = 0;
	localparam int MAP_TWO_LO   = 4;
	localparam int MAP_W        = 4;
	localparam int CTRL_EN_BIT  = 0;
	localparam int STAT_TWO_LO  = 4;
	localparam int STAT_CNT_LO  = 8;

	// ------------------------------------------------------------
	// boost codes and signed percent levels
	// ------------------------------------------------------------
	localparam logic [2:0] BST_NOM  = 3'h0;
	localparam logic [2:0] BST_M5   = 3'h1;
	localparam logic [2:0] BST_P10  = 3'h2;
	localparam logic [2:0] BST_P5   = 3'h3;
	localparam logic [2:0] BST_P20  = 3'h4;
	localparam logic [2:0] BST_P15  = 3'h5;
	localparam logic [2:0] BST_P25  = 3'h6;
	localparam logic signed [7:0] PCT_NOM = 8'sh00;
	localparam logic signed [7:0] PCT_M5  = -8'sh05;
	localparam logic signed [7:0] PCT_P5  = 8'sh05;
	localparam logic signed [7:0] PCT_P10 = 8'sh0a;
	localparam logic signed [7:0] PCT_P15 = 8'sh0f;
	localparam logic signed [7:0] PCT_P20 = 8'sh14;
	localparam logic signed [7:0] PCT_P25 = 8'sh19;

	// ------------------------------------------------------------
	// remap codes
	// ------------------------------------------------------------
	localparam logic [3:0] MAP_OFF   = 4'h0;
	localparam logic [3:0] MAP_MAXOK = 4'h3;
	localparam logic [3:0] DEF_ONE   = 4'h1;
	localparam logic [3:0] DEF_TWO   = 4'h2;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HRESP_OKAY    = 2'h0;
	localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;

endpackage : hpr_pkg

/* File: verif/hpr_host_model.sv */
/* hpr_host_model: upstream host side, numbers downstream ports.
 * assumes the reported count is stable while enumeration runs. */
`timescale 1ns/1ps
module hpr_host_model (
	input  wire logic       core_clk,
	input  wire logic [1:0] reportedPortCount,
	output logic [3:0]      hostTopPort
);
	// ------------------------------------------------------------
	// enumeration
	// ------------------------------------------------------------
	// numbers 1 up to count
	always_ff @(posedge core_clk) begin
		hostTopPort <= {2'b00, reportedPortCount};
	end
endmodule : hpr_host_model

/* File: verif/hpr_port_regs_properties.sv */
/* hpr_port_regs_properties: assertions on hpr_port_regs ports.
 * assumes one core_clk domain, rst_n synchronous active low. */
`timescale 1ns/1ps
module hpr_port_checker
	import hpr_pkg::*;
(
	input wire logic              core_clk,
	input wire logic              rst_n,
	input wire logic              hsel,
	input wire logic [1:0]        htrans,
	input wire logic              hwrite,
	input wire logic [31:0]       hrdata,
	input wire logic [3:1]        txPlus,
	input wire logic [3:1]        txMinus,
	input wire logic [3:1]        dpOut,
	input wire logic [3:1]        dmOut,
	input wire logic [2:0]        hs_current_boost_port_one,
	input wire logic [2:0]        hs_current_boost_port_two,
	input wire logic signed [7:0] boostPctOne,
	input wire logic signed [7:0] boostPctTwo,
	input wire logic [3:0]        logicalPortOne,
	input wire logic [3:0]        logicalPortTwo,
	input wire logic [1:0]        reportedPortCount
);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	localparam logic signed [7:0] PCT_TAB [8] = '{PCT_NOM, PCT_M5, PCT_P10, PCT_P5,
		PCT_P20, PCT_P15, PCT_P25, PCT_NOM};
	logic wrTaken;
	assign wrTaken = hsel && htrans == HTRANS_NONSEQ && hwrite;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_pin_diff_kept: assert property (
		$past(rst_n) |-> (dpOut ^ dmOut) == $past(txPlus ^ txMinus))
		else $error("pin pair difference lost");
	a_pin_equal_pass: assert property (
		$past(rst_n) |-> ((dpOut ^ $past(txPlus)) & ~$past(txPlus ^ txMinus)) == 3'h0)
		else $error("equal pin data altered");
	a_pct_one_code: assert property (
		$stable(hs_current_boost_port_one) |-> boostPctOne == PCT_TAB[hs_current_boost_port_one])
		else $error("port one boost level wrong");
	a_pct_two_code: assert property (
		$stable(hs_current_boost_port_two) |-> boostPctTwo == PCT_TAB[hs_current_boost_port_two])
		else $error("port two boost level wrong");
	a_count_enabled: assert property (
		$stable({logicalPortOne, logicalPortTwo}) |-> reportedPortCount
		== {1'b0, logicalPortOne != MAP_OFF} + {1'b0, logicalPortTwo != MAP_OFF})
		else $error("port count wrong");
	a_logical_range: assert property (
		logicalPortOne <= MAP_MAXOK && logicalPortTwo <= MAP_MAXOK)
		else $error("logical port out of range");
	a_boost_write_only: assert property (
		$changed({hs_current_boost_port_one, hs_current_boost_port_two}) |-> $past(wrTaken, 2))
		else $error("boost changed without write");
	a_map_write_only: assert property (
		$changed({logicalPortOne, logicalPortTwo}) |-> $past(wrTaken, 2) || $past(wrTaken, 3))
		else $error("logical port changed without write");
	a_rdata_upper_zero: assert property (
		hrdata[31:10] == 22'h0)
		else $error("read data upper bits set");
endmodule : hpr_port_checker

bind hpr_port_regs hpr_port_checker u_hpr_chk (
	.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hrdata(hrdata), .txPlus(txPlus), .txMinus(txMinus), .dpOut(dpOut), .dmOut(dmOut),
	.hs_current_boost_port_one(hs_current_boost_port_one),
	.hs_current_boost_port_two(hs_current_boost_port_two),
	.boostPctOne(boostPctOne), .boostPctTwo(boostPctTwo), .logicalPortOne(logicalPortOne),
	.logicalPortTwo(logicalPortTwo), .reportedPortCount(reportedPortCount)
);

/* File: verif/hpr_port_regs_tb_top.sv */
/* hpr_port_regs_tb_top: self-checking bench for hpr_port_regs.
 * assumes a zero-wait AHB-Lite slave and the host model beside it. */
`timescale 1ns/1ps
module hpr_port_regs_tb_top;
	import hpr_pkg::*;
	// ------------------------------------------------------------
	// signals, tasks and sequence
	// ------------------------------------------------------------
	logic core_clk, rst_n, hsel, hwrite, hreadyout;
	logic [1:0] htrans, hresp, reportedPortCount;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [3:1] txPlus, txMinus, dpOut, dmOut, p, m;
	logic [2:0] bstOne, bstTwo;
	logic signed [7:0] boostPctOne, boostPctTwo;
	logic [3:0] logicalPortOne, logicalPortTwo, hostTopPort;
	logic [7:0] sw, rm;
	int n_mismatch = 0, num_checks = 0, seed = 86813;
	localparam logic signed [7:0] PCT_TAB [8] = '{PCT_NOM, PCT_M5, PCT_P10, PCT_P5,
		PCT_P20, PCT_P15, PCT_P25, PCT_NOM};
	localparam logic [7:0] CORNER [4] = '{8'h12, 8'h40, 8'hf3, 8'h5c};

	hpr_port_regs dut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .txPlus(txPlus),
		.txMinus(txMinus), .dpOut(dpOut), .dmOut(dmOut), .hs_current_boost_port_one(bstOne),
		.hs_current_boost_port_two(bstTwo), .boostPctOne(boostPctOne),
		.boostPctTwo(boostPctTwo), .logicalPortOne(logicalPortOne),
		.logicalPortTwo(logicalPortTwo), .reportedPortCount(reportedPortCount));
	hpr_host_model host (.core_clk(core_clk), .reportedPortCount(reportedPortCount),
		.hostTopPort(hostTopPort));

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		txPlus <= 3'($random(seed));
		txMinus <= 3'($random(seed));
	end

	function automatic logic [3:0] mapf(logic [3:0] c);
		return (c > MAP_MAXOK) ? MAP_OFF : c;
	endfunction : mapf

	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic xfer(logic w, logic [7:0] idx, logic [31:0] d);
		@(posedge core_clk);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'b00};
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		q = hrdata;
		chk("response", {30'h0, hresp}, {30'h0, HRESP_OKAY});
	endtask : xfer

	task automatic resets;
		xfer(1'b0, IDX_BOOST, WORD_ZERO);
		chk("boost reset", q, {24'h0, RST_BOOST});
		xfer(1'b0, IDX_SWAP, WORD_ZERO);
		chk("swap reset", q, {24'h0, RST_SWAP});
		xfer(1'b0, IDX_REMAP, WORD_ZERO);
		chk("remap reset", q, 32'h21);
		xfer(1'b0, 8'h10, WORD_ZERO);
		chk("unmapped", q, WORD_ZERO);
		chk("port one reset", {28'h0, logicalPortOne}, {28'h0, DEF_ONE});
		chk("port two reset", {28'h0, logicalPortTwo}, {28'h0, DEF_TWO});
		chk("count reset", {30'h0, reportedPortCount}, 32'h2);
	endtask : resets

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : give_verdict

	initial begin
		#(40 * 5000);
		n_mismatch++;
		give_verdict();
	end

	initial begin
		{rst_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		resets();
		for (int c = 0; c < 8; c++) begin
			xfer(1'b1, IDX_BOOST, {24'h0, 1'b1, 3'(c), 1'b1, 3'(7 - c)});
			xfer(1'b0, IDX_BOOST, WORD_ZERO);
			chk("boost read", q, {25'h0, 3'(c), 1'b0, 3'(7 - c)});
			chk("boost two", {29'h0, bstTwo}, 32'(c));
			chk("boost one", {29'h0, bstOne}, 32'(7 - c));
			chk("level two", {24'h0, boostPctTwo}, {24'h0, PCT_TAB[c]});
			chk("level one", {24'h0, boostPctOne}, {24'h0, PCT_TAB[7 - c]});
		end
		// swap patterns on random pin data
		for (int i = 0; i < 6; i++) begin
			sw = (i == 0) ? 8'hf1 : 8'($random(seed));
			xfer(1'b1, IDX_SWAP, {24'h0, sw});
			xfer(1'b0, IDX_SWAP, WORD_ZERO);
			chk("swap read", q, {24'h0, sw & MASK_SWAP});
			repeat (4) begin
				@(negedge core_clk);
				p = txPlus;
				m = txMinus;
				@(negedge core_clk);
				chk("dp pins", {29'h0, dpOut}, {29'h0, (p & ~sw[3:1]) | (m & sw[3:1])});
				chk("dm pins", {29'h0, dmOut}, {29'h0, (m & ~sw[3:1]) | (p & sw[3:1])});
			end
		end
		xfer(1'b1, IDX_CTRL, 32'h1);
		for (int i = 0; i < 10; i++) begin
			rm = (i < 4) ? CORNER[i] : 8'($random(seed));
			xfer(1'b1, IDX_REMAP, {24'h0, rm});
			xfer(1'b0, IDX_REMAP, WORD_ZERO);
			chk("remap read", q, {24'h0, rm});
			chk("port one", {28'h0, logicalPortOne}, {28'h0, mapf(rm[3:0])});
			chk("port two", {28'h0, logicalPortTwo}, {28'h0, mapf(rm[7:4])});
			chk("host top", {28'h0, hostTopPort}, 32'(mapf(rm[3:0]) != 0) + 32'(mapf(rm[7:4]) != 0));
			xfer(1'b0, IDX_STATUS, WORD_ZERO);
			chk("status", q, {22'h0, 2'(mapf(rm[3:0]) != 0) + 2'(mapf(rm[7:4]) != 0),
				mapf(rm[7:4]), mapf(rm[3:0])});
		end
		xfer(1'b1, IDX_CTRL, WORD_ZERO);
		xfer(1'b0, IDX_CTRL, WORD_ZERO);
		chk("ctrl read", q, WORD_ZERO);
		chk("port one off", {28'h0, logicalPortOne}, {28'h0, DEF_ONE});
		chk("port two off", {28'h0, logicalPortTwo}, {28'h0, DEF_TWO});
		@(posedge core_clk);
		rst_n <= 1'b0;
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		resets();
		give_verdict();
	end
endmodule : hpr_port_regs_tb_top
